/* File: core/pmir_pkg.sv */
// Package for the power mode, identification and init register bank.
// Assumes a 32-bit Avalon-MM slave with byte addressing on a single clock.
package pmir_pkg;
	localparam int PMIR_ADDR_W = 16;
	localparam int PMIR_DATA_W = 32;
	// Register byte addresses
	localparam logic [15:0] PMIR_MAKER_ID_ADDR = 16'h0400;
	localparam logic [15:0] PMIR_PART_REV_ADDR = 16'h0404;
	localparam logic [15:0] PMIR_PWR_BW_ADDR = 16'h22F0;
	localparam logic [15:0] PMIR_STATUS_ADDR = 16'h22F4;
	// Power mode register layout
	localparam logic [31:0] PMIR_PWR_BW_RESET = 32'h00088800;
	localparam logic [31:0] PMIR_PWR_BW_RO_MASK = 32'hFFFFFFF2;
	localparam int PMIR_BW_LSB = 2;
	localparam int PMIR_BW_MSB = 3;
	localparam int PMIR_HS_BIT = 0;
	// Identity codes, values arbitrary
	localparam logic [15:0] PMIR_MAKER_ID_DEF = 16'h1234;
	localparam logic [11:0] PMIR_PART_ID_DEF = 12'hABC;
	localparam logic [3:0] PMIR_REV_DEF = 4'h1;
	// Init sequence length
	localparam logic [3:0] PMIR_INIT_LEN = 4'hA;
	// Filter cutoff codes
	typedef enum logic [1:0] {
		PMIR_BW_AUTO = 2'b00,
		PMIR_BW_50K = 2'b01,
		PMIR_BW_100K = 2'b10,
		PMIR_BW_250K = 2'b11
	} pmir_bw_t;
	typedef enum logic [2:0] {
		PMIR_CUT_5K = 3'h0,
		PMIR_CUT_50K = 3'h1,
		PMIR_CUT_100K = 3'h2,
		PMIR_CUT_250K = 3'h3
	} pmir_cut_t;
	// Waveform frequency bands (from generator, same clock)
	typedef enum logic [1:0] {
		PMIR_WF_LOW = 2'b00,
		PMIR_WF_MID = 2'b01,
		PMIR_WF_HIGH = 2'b10
	} pmir_wf_t;
	typedef struct packed {
		pmir_cut_t dac_cutoff;
		pmir_cut_t adc_cutoff;
		logic high_speed;
	} pmir_analog_t;
endpackage

/* File: core/pmir_regs.sv */
// Power mode, filter bandwidth and identification register bank.
// Assumes an Avalon-MM master on clk and a waveform band from the same clock.
//
// Operation
// (RQ1) Bandwidth field bits 3:2 sets both filters
// (RQ2) Code 00 picks cutoff from waveform band
// (RQ3) Codes 01..11 fix 50/100/250 kHz
// (RQ4) Bit 0 selects low power or high speed
// (RQ5) Host clears bit below 80 kHz
// (RQ6) Reset 0x00088800, reserved bits fixed
// (RQ7) Read-only constant maker identifier
// (RQ8) Part code 15:4, revision 3:0
// (RQ9) Host writes ten-step init after reset
// (RQ10) First five init writes in order
// (RQ11) Last five init writes in order
// (RQ12) Identifier writes have no effect
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pmir_regs #(
	parameter logic [15:0] MAKER_ID = pmir_pkg::PMIR_MAKER_ID_DEF,
	parameter logic [11:0] PART_ID = pmir_pkg::PMIR_PART_ID_DEF,
	parameter logic [3:0] REVISION = pmir_pkg::PMIR_REV_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [pmir_pkg::PMIR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pmir_pkg::PMIR_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [pmir_pkg::PMIR_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire pmir_pkg::pmir_wf_t wave_band,
	output pmir_pkg::pmir_analog_t analog_cfg
);
	import pmir_pkg::*;

	// Handshake states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} pmir_bus_state_t;

	// Bit positions of the one-hot register select
	localparam int SEL_MAKER = 0;
	localparam int SEL_PART = 1;
	localparam int SEL_PWR = 2;
	localparam int SEL_STATUS = 3;

	pmir_bus_state_t bus_state;
	pmir_bus_state_t next_bus_state;

	logic [31:0] power_bandwidth_config;
	logic [31:0] next_power_bandwidth_config;

	logic [3:0] init_count;
	logic [3:0] next_init_count;
	logic init_done;

	logic req;
	logic ack;
	logic wr_take;
	logic rd_launch;
	logic wr_launch;

	logic [31:0] wmask;
	logic [3:0] sel;
	logic hit;

	logic [31:0] next_readdata;
	logic [1:0] next_response;

	logic [1:0] bw_code;
	logic hs_code;
	pmir_cut_t next_cut;

	// Address decode, shared by hit and read mux
	function automatic logic [3:0] addr_select(input logic [15:0] addr);
		logic [3:0] s;
		s = 4'h0;
		s[SEL_MAKER] = (addr == PMIR_MAKER_ID_ADDR);
		s[SEL_PART] = (addr == PMIR_PART_REV_ADDR);
		s[SEL_PWR] = (addr == PMIR_PWR_BW_ADDR);
		s[SEL_STATUS] = (addr == PMIR_STATUS_ADDR);
		return s;
	endfunction

	// (RQ6) Only writable bits take lane data
	function automatic logic [31:0] merge_write(input logic [31:0] cur,
		input logic [31:0] data, input logic [31:0] lanes);
		logic [31:0] keep;
		keep = PMIR_PWR_BW_RO_MASK | ~lanes;
		return (cur & keep) | (data & ~keep);
	endfunction

	// Status: done flag above the saturating count
	function automatic logic [31:0] status_word(input logic [3:0] count);
		logic [31:0] w;
		w = 32'h0;
		w[3:0] = count;
		w[4] = (count == PMIR_INIT_LEN);
		return w;
	endfunction

	assign req = avs_read | avs_write;
	assign ack = (bus_state == BUS_ACK);

	// One wait cycle keeps read data registered
	assign avs_waitrequest = req & ~ack;

	assign sel = addr_select(avs_address);
	assign hit = |sel;

	// Writes land only at the acknowledge edge
	assign wr_take = avs_write & ack;
	assign rd_launch = avs_read & ~ack;
	assign wr_launch = avs_write & ~ack;

	generate
		for (genvar g = 0; g < 4; g++) begin : g_lane
			assign wmask[g*8 +: 8] = {8{avs_byteenable[g]}};
		end
	endgenerate

	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (req) begin
					next_bus_state = BUS_ACK;
				end
			end
			BUS_ACK: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// Back to back requests still see one wait cycle each
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// (RQ6) Reserved bits kept
	always_comb begin
		next_power_bandwidth_config = power_bandwidth_config;
		if (wr_take && sel[SEL_PWR]) begin
			next_power_bandwidth_config = merge_write(power_bandwidth_config,
				avs_writedata, wmask);
		end
	end

	// (RQ6) Reset value
	always_ff @(posedge clk) begin
		if (!nrst) begin
			power_bandwidth_config <= PMIR_PWR_BW_RESET;
		end else begin
			power_bandwidth_config <= next_power_bandwidth_config;
		end
	end

	// Count only; the init order is the host's duty
	assign init_done = (init_count == PMIR_INIT_LEN);

	always_comb begin
		next_init_count = init_count;
		if (wr_take && !init_done) begin
			next_init_count = init_count + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			init_count <= 4'h0;
		end else begin
			init_count <= next_init_count;
		end
	end

	// (RQ7) (RQ8) (RQ12) Identifiers are constants
	always_comb begin
		next_readdata = 32'h0;
		if (sel[SEL_MAKER]) begin
			next_readdata = {16'h0, MAKER_ID};
		end else if (sel[SEL_PART]) begin
			next_readdata = {16'h0, PART_ID, REVISION};
		end else if (sel[SEL_PWR]) begin
			next_readdata = power_bandwidth_config;
		end else if (sel[SEL_STATUS]) begin
			next_readdata = status_word(init_count);
		end
	end

	// Unmapped addresses answer with a slave error
	always_comb begin
		next_response = hit ? 2'b00 : 2'b10;
	end

	// Read data stands until the next read is launched
	always_ff @(posedge clk) begin
		if (!nrst) begin
			avs_readdata <= 32'h0;
		end else if (rd_launch) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			avs_response <= 2'b00;
		end else if (rd_launch || wr_launch) begin
			avs_response <= next_response;
		end
	end

	// (RQ1) (RQ2) (RQ3) Filter cutoff select
	function automatic pmir_cut_t cutoff(input logic [1:0] bw, input pmir_wf_t band);
		case (bw)
			PMIR_BW_50K: cutoff = PMIR_CUT_50K;
			PMIR_BW_100K: cutoff = PMIR_CUT_100K;
			PMIR_BW_250K: cutoff = PMIR_CUT_250K;
			default: begin
				case (band)
					PMIR_WF_MID: cutoff = PMIR_CUT_100K;
					PMIR_WF_HIGH: cutoff = PMIR_CUT_250K;
					default: cutoff = PMIR_CUT_5K;
				endcase
			end
		endcase
	endfunction

	assign bw_code = power_bandwidth_config[PMIR_BW_MSB:PMIR_BW_LSB];
	assign hs_code = power_bandwidth_config[PMIR_HS_BIT];

	// Band is on clk already, so no synchroniser
	assign next_cut = cutoff(bw_code, wave_band);

	// One shared cutoff, so the two filters never disagree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			analog_cfg <= '0;
		end else begin
			analog_cfg.dac_cutoff <= next_cut;
			analog_cfg.adc_cutoff <= next_cut;
			// (RQ4) Power mode bit
			analog_cfg.high_speed <= hs_code;
		end
	end
endmodule

/* File: sim/pmir_props.sv */
// Checker for the power mode and id bank.
// Sees only the bank ports.
`timescale 1ns/1ps
module pmir_props import pmir_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire pmir_pkg::pmir_analog_t analog_cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire ok = !avs_waitrequest;
	wire pw = avs_write && ok && avs_address == PMIR_PWR_BW_ADDR;
	wire rk = avs_read && ok;
	chk_bw_pair: assert property (analog_cfg[6:4] == analog_cfg[3:1])
		else $error("cutoffs differ");
	chk_bw_fixed: assert property (pw && avs_writedata[3:2] != 0 |-> ##2
		analog_cfg[6:4] == $past(avs_writedata[3:2], 2)) else $error("bad cutoff");
	chk_hs_mode: assert property (pw |-> ##2 analog_cfg[0] == $past(avs_writedata[0], 2))
		else $error("bad power mode");
	chk_resv_bits: assert property (rk && avs_address == PMIR_PWR_BW_ADDR |=>
		(avs_readdata & PMIR_PWR_BW_RO_MASK) == PMIR_PWR_BW_RESET) else $error("bad reserved");
	chk_maker_id: assert property (rk && avs_address == PMIR_MAKER_ID_ADDR |=>
		avs_readdata == {16'h0, PMIR_MAKER_ID_DEF}) else $error("bad maker id");
	chk_part_id: assert property (rk && avs_address == PMIR_PART_REV_ADDR |=>
		avs_readdata[15:0] == {PMIR_PART_ID_DEF, PMIR_REV_DEF}) else $error("bad part id");
	cover property (pw);
	cover property (rk);
	cover property (analog_cfg[6:4] == 3'h3);
endmodule
bind pmir_regs pmir_props pmir_props_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .analog_cfg);

/* File: sim/pmir_host.sv */
// Host model: Avalon-MM master for the bank.
// Assumes one clock; the bench calls its task.
`timescale 1ns/1ps
module pmir_host (
	input wire logic clk,
	input wire logic wt,
	input wire logic [31:0] rdat,
	output logic [15:0] a = 0,
	output logic rd = 0,
	output logic wr = 0,
	output logic [31:0] wd = 0
);
	// Held until ack; one idle edge between requests
	task automatic xfer(input logic w, input logic [15:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		a <= ad;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk iff !wt);
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask
endmodule

/* File: sim/test_pmir_regs.sv */
// Bench for the power mode and id bank.
// Assumes the host model drives the bus.
`timescale 1ns/1ps
module test_pmir_regs;
	import pmir_pkg::*;
	logic clk = 0, nrst = 0, rd, wr, wt;
	logic [15:0] a;
	logic [31:0] wd, rdat, q;
	logic [1:0] rsp;
	logic [2:0] e;
	pmir_wf_t band = PMIR_WF_LOW;
	pmir_analog_t cfg;
	int n_fail = 0, n_compared = 0;
	logic [15:0] ia [10] = '{16'h0908, 16'h0C08, 16'h21F0, 16'h0410, 16'h0A28, 16'h238C,
		16'h0A04, 16'h0A04, 16'h0A00, 16'h22F0};
	logic [15:0] id [10] = '{16'h02C9, 16'h206C, 16'h0010, 16'h02C9, 16'h0009, 16'h0104,
		16'h4859, 16'hF27B, 16'h8009, 16'h0000};
	pmir_host pmir_host_inst (.clk, .wt, .rdat, .a, .rd, .wr, .wd);
	pmir_regs pmir_regs_inst (.clk, .nrst, .avs_address(a), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt),
		.avs_response(rsp), .wave_band(band), .analog_cfg(cfg));
	initial forever #5 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] s, x);
		n_compared++;
		if (s !== x) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic rdc(input logic [15:0] ad, input logic [31:0] x);
		pmir_host_inst.xfer(0, ad, 32'h0, q);
		chk("read", q, x);
	endtask
	task automatic final_report;
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100us;
		n_fail++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		for (int i = 0; i < 10; i++) pmir_host_inst.xfer(1, ia[i], 32'(id[i]), q);
		rdc(PMIR_STATUS_ADDR, 32'h1A);
		rdc(PMIR_PWR_BW_ADDR, PMIR_PWR_BW_RESET);
		pmir_host_inst.xfer(1, PMIR_MAKER_ID_ADDR, 32'hFFFFFFFF, q);
		rdc(PMIR_MAKER_ID_ADDR, {16'h0, PMIR_MAKER_ID_DEF});
		rdc(PMIR_PART_REV_ADDR, {16'h0, PMIR_PART_ID_DEF, PMIR_REV_DEF});
		rdc(16'h0100, 32'h0);
		chk("resp", 32'(rsp), 32'h2);
		for (int i = 0; i < 12; i++) begin
			e = i / 3 ? 3'(i / 3) : 3'(i % 3 ? i % 3 + 1 : 0);
			band <= pmir_wf_t'(i % 3);
			pmir_host_inst.xfer(1, PMIR_PWR_BW_ADDR, 32'hFFFFFFF2 | 32'(i / 3 * 4 + i % 2), q);
			rdc(PMIR_PWR_BW_ADDR, PMIR_PWR_BW_RESET | 32'(i / 3 * 4 + i % 2));
			chk("cfg", 32'(cfg), 32'({e, e, 1'(i % 2)}));
		end
		final_report;
	end
endmodule
